/* chm_pkg.sv */
// package of constants and carrier types for the coprocessor hang monitor
package chm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned HANG_LIMIT_MS   = 1000;
  localparam int unsigned HANG_CYCLES     = (CLK_HZ / 1000) * HANG_LIMIT_MS;
  localparam int unsigned HANG_CNT_W      = 28;

  // ==========================================================
  // probe variants
  localparam logic [1:0] PROBE_FIRST  = 2'h0;
  localparam logic [1:0] PROBE_SECOND = 2'h1;
  localparam logic [1:0] PROBE_THIRD  = 2'h2;

  // ==========================================================
  // unit selection and hang enable reset value
  localparam int unsigned NUM_UNITS  = 4;
  localparam int unsigned UNIT_W     = 2;
  localparam logic        ENABLE_RST = 1'b1;

  // ==========================================================
  // field positions of one unit's pin snapshot (16 bits)
  localparam int unsigned PIN_W            = 16;
  localparam int unsigned PIN_RESET        = 0;
  localparam int unsigned PIN_NMI          = 1;
  localparam int unsigned PIN_INTR0        = 2;
  localparam int unsigned PIN_INTR1        = 3;
  localparam int unsigned PIN_INTR2        = 4;
  localparam int unsigned PIN_INTR3        = 5;
  localparam int unsigned PIN_HOLD         = 6;
  localparam int unsigned PIN_HOLD_ACK     = 7;
  localparam int unsigned PIN_READY        = 8;
  localparam int unsigned PIN_SYNC_READY   = 9;
  localparam int unsigned PIN_TEST         = 10;
  localparam int unsigned PIN_MIN_MAX      = 11;
  localparam int unsigned PIN_GRANT0       = 12;
  localparam int unsigned PIN_GRANT1       = 13;
  localparam int unsigned PIN_COPRO_ERR    = 14;
  localparam int unsigned PIN_COPRO_BUSY   = 15;
  localparam logic [15:0] PIN_RST_VAL      = 16'h0000;

  // raw pin levels of one unit, as they arrive at the probe
  typedef struct packed {
    logic reset_lvl;
    logic nmi;
    logic [3:0] intr;
    logic hold;
    logic hold_acknowledge;
    logic ready_lvl;
    logic sync_ready;
    logic test_n;
    logic min_max_select;
    logic bus_request_grant_0;
    logic bus_request_grant_1;
    logic coprocessor_error_n;
    logic coprocessor_busy_n;
    logic coprocessor_extension_request;
  } chm_pins_type;

  // coprocessor access indications
  typedef struct packed {
    logic int_active;
    logic ext_active;
  } chm_access_type;

  // hang timer state
  typedef enum logic [1:0] {
    HT_IDLE    = 2'b00,
    HT_TIMING  = 2'b01,
    HT_EXPIRED = 2'b11
  } chm_hang_state_type;

endpackage

/* chm_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
`default_nettype none
module chm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } chm_sync_st_type;

  chm_sync_st_type st_q;
  chm_sync_st_type st_d;

  // first stage feeds only the second
  always_comb begin
    st_d      = st_q;
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.sync;

endmodule
`default_nettype wire

/* chm_hang_monitor.sv */
// coprocessor hang monitor with pin status snapshot
// ==========================================================
// Functional notes
// - enabled access over one second signals time-out
// - first probe watches internal and external coprocessor
// - second probe watches external coprocessor only
// - enable write takes only bit zero
// - enable holds until written or reset
// - each time-out gives host a visible event
// - target reset hits probe, not coprocessors
// - snapshot shows present levels, nothing latched
// - snapshot per unit zero to three, or all
// - first probe min/max line reads one in minimum mode
// - third probe ready/error/busy active low
`timescale 1ns/10ps
`default_nettype none
module chm_hang_monitor
  import chm_pkg::*;
#(
  parameter logic [1:0]  PROBE_TYPE = PROBE_FIRST,
  parameter int unsigned HANG_COUNT = HANG_CYCLES
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  input  wire logic                        i_enable_wr,
  input  wire logic [7:0]                  i_enable_wdata,
  input  wire chm_access_type              i_access,
  input  wire logic                        i_target_reset,
  input  wire logic                        i_target_reset_enable,
  input  wire chm_pins_type [NUM_UNITS-1:0] i_pins,
  input  wire logic [UNIT_W-1:0]           i_unit_sel,
  input  wire logic                        i_unit_all,
  output logic                             o_coprocessor_hang_enable,
  output logic                             o_timeout_event,
  output logic                             o_timeout_active,
  output logic                             o_probe_reset,
  output logic                             o_coprocessor_reset,
  output logic [NUM_UNITS*PIN_W-1:0]       o_pin_status
);

  // ==========================================================
  // synchronise all pin inputs
  localparam int unsigned PINS_W = $bits(chm_pins_type);
  localparam int unsigned RAW_W  = NUM_UNITS * PINS_W + 3;

  logic [RAW_W-1:0] raw_s;

  chm_sync #(
    .WIDTH (RAW_W)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_pins, i_access, i_target_reset}),
    .o_sync    (raw_s)
  );

  chm_pins_type [NUM_UNITS-1:0] pins_s;
  chm_access_type               acc_s;
  logic                         trst_s;

  assign pins_s = raw_s[RAW_W-1 -: NUM_UNITS*PINS_W];
  assign acc_s  = raw_s[2:1];
  assign trst_s = raw_s[0];

  // ==========================================================
  // module state
  typedef struct packed {
    logic                        enable;
    chm_hang_state_type          hstate;
    logic [HANG_CNT_W-1:0]       count;
    logic                        event_p;
    logic                        watched_prev;
    logic                        probe_rst;
    logic [NUM_UNITS*PIN_W-1:0]  status;
  } chm_st_type;

  chm_st_type st_q;
  chm_st_type st_d;

  localparam logic [HANG_CNT_W-1:0] LIMIT = HANG_COUNT[HANG_CNT_W-1:0];

  logic watched;
  logic [PIN_W-1:0] unit_word [NUM_UNITS];

  // access selection per probe variant
  always_comb begin
    if (PROBE_TYPE == PROBE_SECOND) begin
      watched = acc_s.ext_active;
    end else begin
      watched = acc_s.ext_active | acc_s.int_active;
    end
  end

  // ==========================================================
  // per unit snapshot formatting, present level only
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_unit
      always_comb begin
        unit_word[g] = '0;
        unit_word[g][PIN_RESET]      = pins_s[g].reset_lvl;
        unit_word[g][PIN_NMI]        = pins_s[g].nmi;
        unit_word[g][PIN_HOLD]       = pins_s[g].hold;
        unit_word[g][PIN_TEST]       = pins_s[g].test_n;
        if (PROBE_TYPE == PROBE_THIRD) begin
          // third probe: ready/error/busy active low
          unit_word[g][PIN_INTR0]      = pins_s[g].intr[0];
          unit_word[g][PIN_READY]      = pins_s[g].ready_lvl;
          unit_word[g][PIN_COPRO_ERR]  = pins_s[g].coprocessor_error_n;
          unit_word[g][PIN_COPRO_BUSY] = pins_s[g].coprocessor_busy_n;
          unit_word[g][PIN_SYNC_READY] =
            pins_s[g].coprocessor_extension_request;
        end else if (PROBE_TYPE == PROBE_SECOND) begin
          unit_word[g][PIN_INTR3:PIN_INTR0] = pins_s[g].intr;
          unit_word[g][PIN_READY]      = pins_s[g].ready_lvl;
          unit_word[g][PIN_SYNC_READY] = pins_s[g].sync_ready;
        end else begin
          unit_word[g][PIN_INTR0]      = pins_s[g].intr[0];
          unit_word[g][PIN_HOLD_ACK]   = pins_s[g].hold_acknowledge;
          unit_word[g][PIN_READY]      = pins_s[g].ready_lvl;
          // 1 in minimum mode, 0 in maximum mode
          unit_word[g][PIN_MIN_MAX]    = pins_s[g].min_max_select;
          unit_word[g][PIN_GRANT0]     = pins_s[g].bus_request_grant_0;
          unit_word[g][PIN_GRANT1]     = pins_s[g].bus_request_grant_1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    st_d         = st_q;
    st_d.event_p = 1'b0;
    st_d.watched_prev = watched;
    // enable takes only the low bit
    if (i_enable_wr) begin
      st_d.enable = i_enable_wdata[0];
    end
    // hang timer
    case (st_q.hstate)
      HT_IDLE: begin
        st_d.count = '0;
        if (watched && st_q.enable) begin
          st_d.hstate = HT_TIMING;
        end
      end
      HT_TIMING: begin
        if (!watched || !st_q.enable) begin
          st_d.hstate = HT_IDLE;
          st_d.count  = '0;
        end else if (st_q.count == LIMIT - 1'b1) begin
          st_d.hstate  = HT_EXPIRED;
          st_d.event_p = 1'b1;
        end else begin
          st_d.count = st_q.count + 1'b1;
        end
      end
      HT_EXPIRED: begin
        if (!watched || !st_q.enable) begin
          st_d.hstate = HT_IDLE;
          st_d.count  = '0;
        end
      end
      default: begin
        st_d.hstate = HT_IDLE;
        st_d.count  = '0;
      end
    endcase
    // a new access restarts the count
    if (watched && !st_q.watched_prev) begin
      st_d.count = '0;
    end
    // target reset reaches the probe processor only
    st_d.probe_rst = trst_s & i_target_reset_enable;
    // unit selection of the snapshot
    st_d.status = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (i_unit_all || (i_unit_sel == u[UNIT_W-1:0])) begin
        st_d.status[u*PIN_W +: PIN_W] = unit_word[u];
      end
    end
  end

  // ==========================================================
  // state register; enable comes out of reset set
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q              <= '0;
      st_q.enable       <= ENABLE_RST;
      st_q.hstate       <= HT_IDLE;
      st_q.status       <= {NUM_UNITS{PIN_RST_VAL}};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_coprocessor_hang_enable = st_q.enable;
  assign o_timeout_event           = st_q.event_p;
  assign o_timeout_active          = (st_q.hstate == HT_EXPIRED);
  assign o_probe_reset             = st_q.probe_rst;
  assign o_coprocessor_reset       = 1'b0;
  assign o_pin_status              = st_q.status;

endmodule
`default_nettype wire

/* chm_hang_monitor_sva.sv */
// assertion checker for the coprocessor hang monitor
`timescale 1ns/10ps
`default_nettype none
module chm_hang_monitor_sva
  import chm_pkg::*;
#(
  parameter logic [1:0]  PROBE_TYPE = PROBE_FIRST,
  parameter int unsigned HANG_COUNT = HANG_CYCLES
) (
  input wire logic                     i_clk_sys,
  input wire logic                     i_nrst,
  input wire logic                     i_enable_wr,
  input wire logic [7:0]               i_enable_wdata,
  input wire chm_access_type           i_access,
  input wire logic                     i_target_reset,
  input wire logic                     i_target_reset_enable,
  input wire logic [UNIT_W-1:0]        i_unit_sel,
  input wire logic                     i_unit_all,
  input wire logic                     o_coprocessor_hang_enable,
  input wire logic                     o_timeout_event,
  input wire logic                     o_timeout_active,
  input wire logic                     o_probe_reset,
  input wire logic                     o_coprocessor_reset,
  input wire logic [NUM_UNITS*PIN_W-1:0] o_pin_status
);
  // ==========================================================
  // helper: cycles of enabled raw access
  logic [15:0] acc_cnt_q;
  logic        watched_raw;

  // second probe ignores the internal coprocessor
  assign watched_raw = (PROBE_TYPE == PROBE_SECOND) ? i_access.ext_active
                                                    : (|i_access);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  // count enabled access cycles
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) acc_cnt_q <= 16'h0000;
    else if (watched_raw && o_coprocessor_hang_enable)
      acc_cnt_q <= acc_cnt_q + 16'h0001;
    else acc_cnt_q <= 16'h0000;
  end

  sequence s_bus_idle;
    !(|i_access) [*5];
  endsequence
  sequence s_trst_held;
    (i_target_reset && i_target_reset_enable) [*4];
  endsequence

  // ==========================================================
  // properties
  event_pulse_a: assert property (o_timeout_event |=> !o_timeout_event)
    else $error("time-out event wider than one cycle");
  rise_event_a: assert property ($rose(o_timeout_active) |-> o_timeout_event)
    else $error("time-out without event");
  event_late_a: assert property (o_timeout_event |-> acc_cnt_q >= HANG_COUNT)
    else $error("time-out before full count");
  hang_flag_a: assert property (acc_cnt_q == HANG_COUNT + 6 |-> o_timeout_active)
    else $error("long access not flagged");
  off_quiet_a: assert property (!o_coprocessor_hang_enable [*2] |->
    !o_timeout_event && !o_timeout_active) else $error("time-out while off");
  wr_bit0_a: assert property (i_enable_wr |=>
    o_coprocessor_hang_enable == $past(i_enable_wdata[0]))
    else $error("enable not from bit zero");
  en_hold_a: assert property (!i_enable_wr |=> $stable(o_coprocessor_hang_enable))
    else $error("enable changed unwritten");
  idle_clear_a: assert property (s_bus_idle |-> !o_timeout_active)
    else $error("time-out stays after access");
  trst_probe_a: assert property (s_trst_held |-> o_probe_reset && !o_coprocessor_reset)
    else $error("target reset routed wrong");
  trst_off_a: assert property (!i_target_reset_enable |=> !o_probe_reset)
    else $error("probe reset while not enabled");
  unit_sel_a: assert property (!i_unit_all |=> (o_pin_status &
    ~(64'h0000_0000_0000_FFFF << {$past(i_unit_sel), 4'h0})) == 64'h0)
    else $error("unselected unit not zero");
endmodule
bind chm_hang_monitor chm_hang_monitor_sva #(.PROBE_TYPE(PROBE_TYPE),
  .HANG_COUNT(HANG_COUNT)) chk_u (
  .i_clk_sys, .i_nrst, .i_enable_wr, .i_enable_wdata, .i_access,
  .i_target_reset, .i_target_reset_enable, .i_unit_sel, .i_unit_all,
  .o_coprocessor_hang_enable, .o_timeout_event, .o_timeout_active,
  .o_probe_reset, .o_coprocessor_reset, .o_pin_status);
`default_nettype wire

/* chm_copro_model.sv */
// coprocessor model driving memory access levels
`timescale 1ns/10ps
`default_nettype none
module chm_copro_model
  import chm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_start,
  input  wire logic        i_int_sel,
  input  wire logic [15:0] i_len,
  input  wire logic        i_copro_rst,
  output chm_access_type   o_access
);
  // ==========================================================
  // access length counter, cleared by coprocessor reset
  logic [15:0] cnt_q;
  logic        sel_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_copro_rst) cnt_q <= 16'h0000;
    else if (i_start) begin
      cnt_q <= i_len;
      sel_q <= i_int_sel;
    end
    else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
  end

  // one coprocessor active at a time
  assign o_access.int_active = (cnt_q != 16'h0000) && sel_q;
  assign o_access.ext_active = (cnt_q != 16'h0000) && !sel_q;
endmodule
`default_nettype wire

/* chm_hang_monitor_test.sv */
// self-checking bench for the coprocessor hang monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module chm_hang_monitor_test import chm_pkg::*;;
  localparam int unsigned HC = 20;
  logic clk, nrst, en_wr, trst, trst_en, unit_all, go, isel, crst;
  logic hang_en, tevt, tact, prst, crst_out, tevt2;
  logic [NUM_UNITS*PIN_W-1:0] pin_st3;
  logic [7:0] en_wdata;
  logic [15:0] len;
  logic [1:0] unit_sel;
  logic [NUM_UNITS*PIN_W-1:0] pin_st;
  chm_access_type access;
  chm_pins_type [NUM_UNITS-1:0] pins;
  int fail_count, num_checks;

  chm_copro_model cop_u (.i_clk_sys(clk), .i_start(go), .i_int_sel(isel),
    .i_len(len), .i_copro_rst(crst), .o_access(access));
  chm_hang_monitor #(.PROBE_TYPE(PROBE_FIRST), .HANG_COUNT(HC)) dut_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_enable_wr(en_wr),
    .i_enable_wdata(en_wdata), .i_access(access), .i_target_reset(trst),
    .i_target_reset_enable(trst_en), .i_pins(pins), .i_unit_sel(unit_sel),
    .i_unit_all(unit_all), .o_coprocessor_hang_enable(hang_en),
    .o_timeout_event(tevt), .o_timeout_active(tact), .o_probe_reset(prst),
    .o_coprocessor_reset(crst_out), .o_pin_status(pin_st));
  // second probe: external coprocessor only
  chm_hang_monitor #(.PROBE_TYPE(PROBE_SECOND), .HANG_COUNT(HC)) dut2_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_enable_wr(en_wr),
    .i_enable_wdata(en_wdata), .i_access(access), .i_target_reset(trst),
    .i_target_reset_enable(trst_en), .i_pins(pins), .i_unit_sel(unit_sel),
    .i_unit_all(unit_all), .o_coprocessor_hang_enable(),
    .o_timeout_event(tevt2), .o_timeout_active(), .o_probe_reset(),
    .o_coprocessor_reset(), .o_pin_status());
  // third probe: active-low ready, error and busy lines
  chm_hang_monitor #(.PROBE_TYPE(PROBE_THIRD), .HANG_COUNT(HC)) dut3_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_enable_wr(en_wr),
    .i_enable_wdata(en_wdata), .i_access(access), .i_target_reset(trst),
    .i_target_reset_enable(trst_en), .i_pins(pins), .i_unit_sel(unit_sel),
    .i_unit_all(unit_all), .o_coprocessor_hang_enable(),
    .o_timeout_event(), .o_timeout_active(), .o_probe_reset(),
    .o_coprocessor_reset(), .o_pin_status(pin_st3));

  // ==========================================================
  // tasks
  task automatic wr_en(logic [7:0] v);
    @(posedge clk); en_wr <= 1'b1; en_wdata <= v;
    @(posedge clk); en_wr <= 1'b0;
    #1;
  endtask
  task automatic run_acc(logic is_int, int n, int exp_evt, int exp_evt2);
    int cnt;
    int cnt2;
    cnt = 0;
    cnt2 = 0;
    @(posedge clk); go <= 1'b1; isel <= is_int; len <= n[15:0];
    @(posedge clk); go <= 1'b0;
    repeat (n + 12) begin
      @(posedge clk); #1;
      if (tevt !== 1'b0) cnt++;
      if (tevt2 !== 1'b0) cnt2++;
    end
    `CHK(cnt, exp_evt)
    `CHK(cnt2, exp_evt2)
    `CHK(tact, 1'b0)
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0; crst = 1'b1; en_wr = 1'b0; en_wdata = 8'h00; trst = 1'b0;
    trst_en = 1'b0; unit_all = 1'b0; go = 1'b0; isel = 1'b0; len = 16'h0000;
    unit_sel = 2'h0; pins = '0; fail_count = 0; num_checks = 0;
    repeat (10) @(posedge clk);
    crst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHK(hang_en, 1'b1)
    `CHK(crst_out, 1'b0)
    wr_en(8'hFE);
    `CHK(hang_en, 1'b0)
    wr_en(8'h01);
    `CHK(hang_en, 1'b1)
    run_acc(1'b0, 40, 1, 1);
    run_acc(1'b1, 40, 1, 0);
    run_acc(1'b0, HC - 1, 0, 0);
    wr_en(8'h00);
    run_acc(1'b0, 40, 0, 0);
    @(posedge clk); nrst <= 1'b0;
    @(posedge clk); nrst <= 1'b1;
    #1;
    `CHK(hang_en, 1'b1)
    @(posedge clk); trst <= 1'b1; trst_en <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK(prst, 1'b1)
    `CHK(crst_out, 1'b0)
    @(posedge clk); trst_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(prst, 1'b0)
    @(posedge clk); pins[2].min_max_select <= 1'b1; pins[2].nmi <= 1'b1;
    unit_sel <= 2'h2; pins[2].coprocessor_busy_n <= 1'b1;
    settle();
    `CHK(pin_st3[2*PIN_W+PIN_COPRO_BUSY], 1'b1)
    `CHK(pin_st[2*PIN_W+PIN_MIN_MAX], 1'b1)
    `CHK(pin_st[2*PIN_W+PIN_NMI], 1'b1)
    `CHK(pin_st[4*PIN_W-1:3*PIN_W], 16'h0000)
    @(posedge clk); pins[2].nmi <= 1'b0; pins[0].hold <= 1'b1;
    unit_all <= 1'b1; unit_sel <= 2'h1;
    settle();
    `CHK(pin_st[2*PIN_W+PIN_NMI], 1'b0)
    `CHK(pin_st[PIN_HOLD], 1'b1)
    `CHK(pin_st[2*PIN_W+PIN_MIN_MAX], 1'b1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
